// >>> rst_seq.sv
// Reset and stop mode recovery sequencer
`timescale 1ns/100ps
`include "rst_seq_defs.svh"
module rst_seq
   import rst_seq_pkg::*;
#(
   parameter int SHORT_HOLD = `RSQ_SHORT_HOLD_CYC,
   parameter int LONG_HOLD = `RSQ_LONG_HOLD_CYC,
   parameter int CNT_W = `RSQ_CNT_W
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   input wire rst_req_t req_i,
   input wire logic xtal_en_i,
   input wire logic clk_sel_wr_i,
   input wire clk_src_t clk_sel_i,
   output logic core_rst_n_o,
   output logic ctrl_rst_o,
   output logic wdosc_rst_o,
   output logic periph_idle_o,
   output logic xtal_run_o,
   output logic wdt_osc_run_o,
   output clk_src_t clk_src_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   seq_state_t state_r;
   seq_state_t state_nxt;
   rst_kind_t kind_r;
   rst_kind_t kind_nxt;
   logic long_hold_r; // Crystal option used by the hold in progress
   logic cnt_done;
   logic [`RSQ_MON_W-1:0] hold_len_r;

   // Terminal counts, minus one for the load cycle
   localparam logic [CNT_W-1:0] SHORT_LOAD = CNT_W'(SHORT_HOLD - 1);
   localparam logic [CNT_W-1:0] LONG_LOAD = CNT_W'(LONG_HOLD - 1);

   // ----------------------------------------------------------------
   // Decoding functions
   // ----------------------------------------------------------------
   // True when the requests start or restart a system hold
   function automatic logic starts_system(input rst_req_t req, input seq_state_t st);
      return req.sys_req || (!req.pin_n && st == ST_RUN);
   endfunction : starts_system

   // ----------------------------------------------------------------
   // Request decoding
   // ----------------------------------------------------------------
   // A low pin is a system reset source; it beats a stop recovery
   wire sys_start = starts_system(req_i, state_r);
   wire stop_start = req_i.stop_req && !sys_start && (state_r == ST_RUN);
   wire in_load = (state_r == ST_LOAD);
   // Crystal option read at the load edge, so a power-on hold honours it too
   wire [CNT_W-1:0] load_val = xtal_en_i ? LONG_LOAD : SHORT_LOAD;
   wire hold_nxt = (state_nxt != ST_RUN);

   // Next state; a system request restarts any hold in progress
   always_comb begin
      state_nxt = state_r;
      kind_nxt = kind_r;
      if (sys_start) begin
         state_nxt = ST_LOAD;
         kind_nxt = KIND_SYSTEM;
      end else if (stop_start) begin
         state_nxt = ST_LOAD;
         kind_nxt = KIND_STOP;
      end else begin
         case (state_r)
            ST_LOAD: begin
               state_nxt = ST_COUNT;
            end
            ST_COUNT: begin
               if (cnt_done) begin
                  // Pin still low at expiry keeps the core held
                  state_nxt = req_i.pin_n ? ST_RUN : ST_PIN_WAIT;
               end
            end
            ST_PIN_WAIT: begin
               if (req_i.pin_n) begin
                  state_nxt = ST_RUN;
               end
            end
            default: begin
               state_nxt = ST_RUN;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Hold counter
   // ----------------------------------------------------------------
   hold_counter #(
      .CNT_W(CNT_W)
   ) u_hold_counter (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .clk_en_i(clk_en_i),
      .load_i(in_load),
      .load_val_i(load_val),
      .done_o(cnt_done)
   );

   // ----------------------------------------------------------------
   // Output next values
   // ----------------------------------------------------------------
   wire ctrl_rst_nxt = hold_nxt && (kind_nxt == KIND_SYSTEM);
   wire clk_sw = !hold_nxt && clk_sel_wr_i;
   wire clk_src_t clk_src_nxt = hold_nxt ? CLK_PREC : (clk_sw ? clk_sel_i : clk_src_o);

   // State registers; reset starts a system hold
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= ST_LOAD;
         kind_r <= KIND_SYSTEM;
         long_hold_r <= 1'b0;
      end else if (clk_en_i) begin
         state_r <= state_nxt;
         kind_r <= kind_nxt;
         if (in_load) begin
            long_hold_r <= xtal_en_i;
         end
      end
   end

   // Registered outputs
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         core_rst_n_o <= `RSQ_CORE_RST_N_RST;
         ctrl_rst_o <= `RSQ_CTRL_RST_RST;
         wdosc_rst_o <= `RSQ_WDOSC_RST_RST;
         periph_idle_o <= 1'b1;
         xtal_run_o <= 1'b0;
         wdt_osc_run_o <= 1'b1;
         clk_src_o <= CLK_PREC;
      end else if (clk_en_i) begin
         core_rst_n_o <= !hold_nxt;
         ctrl_rst_o <= ctrl_rst_nxt;
         wdosc_rst_o <= hold_nxt;
         periph_idle_o <= hold_nxt;
         xtal_run_o <= xtal_en_i;
         wdt_osc_run_o <= 1'b1;
         clk_src_o <= clk_src_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Length of the current hold, saturating
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hold_len_r <= '0;
      end else if (clk_en_i) begin
         if (core_rst_n_o) begin
            hold_len_r <= '0;
         end else if (hold_len_r != '1) begin
            hold_len_r <= hold_len_r + 1'b1;
         end
      end
   end

   a_short_hold_len: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(core_rst_n_o) && !long_hold_r |-> hold_len_r >= SHORT_HOLD)
      else $error("Short hold ended early");

   a_long_sys_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(core_rst_n_o) && long_hold_r && kind_r == KIND_SYSTEM |-> hold_len_r >= LONG_HOLD)
      else $error("Long system hold ended early");

   a_long_stop_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(core_rst_n_o) && long_hold_r && kind_r == KIND_STOP |-> hold_len_r >= LONG_HOLD)
      else $error("Long stop recovery hold ended early");

   a_stop_keeps_ctrl: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && in_load && kind_r == KIND_STOP && !req_i.sys_req && req_i.pin_n
      |=> !ctrl_rst_o && wdosc_rst_o && !core_rst_n_o)
      else $error("Stop recovery touched other control registers");

   a_sys_loads_ctrl: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && req_i.sys_req |=> ctrl_rst_o && wdosc_rst_o && !core_rst_n_o)
      else $error("System reset did not reset control registers");

   a_pin_holds_core: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && !req_i.pin_n |=> !core_rst_n_o)
      else $error("Core released while reset pin low");

   a_osc_keep_run: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !core_rst_n_o && $past(clk_en_i) && $past(rst_n_i) |-> periph_idle_o && wdt_osc_run_o
      && xtal_run_o == $past(xtal_en_i))
      else $error("Oscillators stopped or peripherals active in reset");

   a_prec_after_rst: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !core_rst_n_o ##1 (core_rst_n_o && !$past(clk_sel_wr_i)) |-> clk_src_o == CLK_PREC)
      else $error("Clock source not internal oscillator after reset");

   a_cnt_expiry: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && state_r == ST_COUNT && cnt_done && req_i.pin_n && !req_i.sys_req
      |=> core_rst_n_o && !ctrl_rst_o && !wdosc_rst_o)
      else $error("Core not released at counter expiry");

   // Frozen clock enable keeps state and outputs
   a_freeze_holds_state: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !clk_en_i |=> $stable(state_r) && $stable(core_rst_n_o) && $stable(ctrl_rst_o)
      && $stable(clk_src_o))
      else $error("State moved while clock enable low");

   // Any system request restarts a system hold
   a_sys_restarts: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && req_i.sys_req |=> state_r == ST_LOAD && kind_r == KIND_SYSTEM)
      else $error("System request did not restart the hold");

   // Pin released while waiting frees the core at the next edge
   a_pin_release: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && state_r == ST_PIN_WAIT && req_i.pin_n && !req_i.sys_req |=> core_rst_n_o)
      else $error("Core not released after reset pin deasserted");

   // Stop request during a hold leaves the hold kind alone
   a_stop_ignored: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && state_r == ST_COUNT && req_i.stop_req && !req_i.sys_req |=> $stable(kind_r))
      else $error("Stop request changed a hold in progress");

   // Stop request taken while running resets the core and wdosc_rst_o, not ctrl_rst_o
   a_stop_take: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && state_r == ST_RUN && req_i.stop_req && !req_i.sys_req && req_i.pin_n
      |=> !core_rst_n_o && !ctrl_rst_o && wdosc_rst_o)
      else $error("Stop recovery start reset the wrong registers");

endmodule : rst_seq

// >>> rst_seq_defs.svh
// Constants for the reset and stop mode recovery sequencer
`ifndef RST_SEQ_DEFS_SVH
`define RST_SEQ_DEFS_SVH

// ----------------------------------------------------------------
// Hold times, in precision oscillator cycles
// ----------------------------------------------------------------
`define RSQ_SHORT_HOLD_CYC 66
`define RSQ_LONG_HOLD_CYC 5000
`define RSQ_CNT_W 13
`define RSQ_MON_W 14

// ----------------------------------------------------------------
// Reset values of outputs
// ----------------------------------------------------------------
`define RSQ_CORE_RST_N_RST 1'b0
`define RSQ_CTRL_RST_RST 1'b1
`define RSQ_WDOSC_RST_RST 1'b1

`endif

// >>> rst_seq_pkg.sv
// Types for the reset and stop mode recovery sequencer
package rst_seq_pkg;

   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_LOAD = 2'b01,
      ST_COUNT = 2'b10,
      ST_PIN_WAIT = 2'b11
   } seq_state_t;

   // Kind of the reset in progress
   typedef enum logic {
      KIND_SYSTEM = 1'b0,
      KIND_STOP = 1'b1
   } rst_kind_t;

   // System clock source choice
   typedef enum logic [1:0] {
      CLK_PREC = 2'b00,
      CLK_XTAL = 2'b01,
      CLK_EXT = 2'b10,
      CLK_WDT = 2'b11
   } clk_src_t;

   // Reset and recovery request bundle
   typedef struct packed {
      logic sys_req;
      logic stop_req;
      logic pin_n;
   } rst_req_t;

endpackage : rst_seq_pkg

// >>> hold_counter.sv
// Loadable down counter for the reset hold period
`timescale 1ns/100ps
module hold_counter #(
   parameter int CNT_W = 13
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   input wire logic load_i,
   input wire logic [CNT_W-1:0] load_val_i,
   output logic done_o
);

   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   wire cnt_zero = (cnt_r == '0);

   // Next count: load, else count down to zero and stop
   assign cnt_nxt = load_i ? load_val_i : (cnt_zero ? cnt_r : cnt_r - 1'b1);

   // Counter and expiry flag
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r <= '0;
         done_o <= 1'b0;
      end else if (clk_en_i) begin
         cnt_r <= cnt_nxt;
         done_o <= (cnt_nxt == '0);
      end
   end

endmodule : hold_counter

// >>> core_model.sv
// Model of the core and peripherals that sit behind the core reset
`timescale 1ns/100ps
module core_model (
   input wire logic sys_clk_i,
   input wire logic core_rst_n_i,
   input wire logic ctrl_rst_i,
   input wire logic wdosc_rst_i,
   output logic [15:0] held_cyc_o,
   output logic saw_ctrl_o,
   output logic saw_wdosc_o
);
   logic prev_n_r = 1'b1;
   // Counts held cycles and records which register groups were reloaded
   always_ff @(posedge sys_clk_i) begin
      prev_n_r <= core_rst_n_i;
      if (!core_rst_n_i && prev_n_r) begin
         held_cyc_o <= 16'h0001;
         saw_ctrl_o <= ctrl_rst_i;
         saw_wdosc_o <= wdosc_rst_i;
      end else if (!core_rst_n_i) begin
         held_cyc_o <= held_cyc_o + 16'h0001; // Core stays idle
         saw_ctrl_o <= saw_ctrl_o | ctrl_rst_i;
         saw_wdosc_o <= saw_wdosc_o | wdosc_rst_i;
      end
   end
endmodule : core_model

// >>> rst_seq_tb.sv
// Self-checking bench for the reset and stop mode recovery sequencer
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module rst_seq_tb;
   import rst_seq_pkg::*;
   localparam int SH = 10;
   localparam int LH = 100;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   rst_req_t req_i = 3'h1;
   logic xtal_en_i = 1'b0;
   logic clk_sel_wr_i = 1'b0;
   clk_src_t clk_sel_i = CLK_PREC;
   logic clk_en = 1'b1;
   logic core_rst_n_o, ctrl_rst_o, wdosc_rst_o, periph_idle_o, xtal_run_o, wdt_osc_run_o;
   clk_src_t clk_src_o;
   logic [15:0] held;
   logic saw_ctrl, saw_wdosc;
   int n_mismatch = 0;
   int num_checks = 0;
   always #10 sys_clk_i = ~sys_clk_i;
   rst_seq #(.SHORT_HOLD(SH), .LONG_HOLD(LH), .CNT_W(13)) i_rst_seq (.sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i), .clk_en_i(clk_en), .req_i(req_i), .xtal_en_i(xtal_en_i),
      .clk_sel_wr_i(clk_sel_wr_i), .clk_sel_i(clk_sel_i), .core_rst_n_o(core_rst_n_o),
      .ctrl_rst_o(ctrl_rst_o), .wdosc_rst_o(wdosc_rst_o), .periph_idle_o(periph_idle_o),
      .xtal_run_o(xtal_run_o), .wdt_osc_run_o(wdt_osc_run_o), .clk_src_o(clk_src_o));
   core_model i_core_model (.sys_clk_i(sys_clk_i), .core_rst_n_i(core_rst_n_o),
      .ctrl_rst_i(ctrl_rst_o), .wdosc_rst_i(wdosc_rst_o), .held_cyc_o(held),
      .saw_ctrl_o(saw_ctrl), .saw_wdosc_o(saw_wdosc));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic close_out();
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out
   task automatic wait_rst(input logic lvl);
      int k;
      k = 0;
      while (core_rst_n_o !== lvl && k < 6000) begin
         @(posedge sys_clk_i);
         #1;
         k++;
      end
      `CHK(core_rst_n_o, lvl)
   endtask : wait_rst
   // Pulses a system or stop request and judges the whole hold
   task automatic run_hold(input logic sys, input logic xt, input int n);
      xtal_en_i <= xt;
      repeat (2) @(posedge sys_clk_i);
      if (sys) req_i.sys_req <= 1'b1;
      else req_i.stop_req <= 1'b1;
      @(posedge sys_clk_i);
      req_i.sys_req <= 1'b0;
      req_i.stop_req <= 1'b0;
      wait_rst(1'b0);
      @(posedge sys_clk_i);
      #1;
      `CHK({periph_idle_o, wdosc_rst_o, wdt_osc_run_o, xtal_run_o}, {3'h7, xt})
      `CHK(ctrl_rst_o, sys)
      `CHK(clk_src_o, CLK_PREC)
      wait_rst(1'b1);
      `CHK({periph_idle_o, ctrl_rst_o, wdosc_rst_o}, 3'h0)
      `CHK((held >= n) && (held <= n + 2), 1'b1)
      `CHK({saw_ctrl, saw_wdosc}, {sys, 1'b1})
   endtask : run_hold
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic pin_extend();
      xtal_en_i <= 1'b0;
      @(posedge sys_clk_i);
      req_i.pin_n <= 1'b0;
      repeat (30) @(posedge sys_clk_i);
      #1;
      `CHK(core_rst_n_o, 1'b0)
      @(posedge sys_clk_i);
      req_i.pin_n <= 1'b1;
      wait_rst(1'b1);
      `CHK((held >= 30) && (held <= 35), 1'b1)
   endtask : pin_extend
   task automatic clock_back_to_prec();
      @(posedge sys_clk_i);
      clk_sel_i <= CLK_XTAL;
      clk_sel_wr_i <= 1'b1;
      @(posedge sys_clk_i);
      clk_sel_wr_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      #1;
      `CHK(clk_src_o, CLK_XTAL)
      run_hold(1'b1, 1'b0, SH);
      `CHK(clk_src_o, CLK_PREC)
   endtask : clock_back_to_prec
   // A second power-on reset with the crystal on gives the long hold
   task automatic por_long_hold();
      xtal_en_i <= 1'b1;
      @(posedge sys_clk_i);
      rst_n_i <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      #1;
      `CHK({core_rst_n_o, ctrl_rst_o, clk_src_o}, {2'h1, CLK_PREC})
      wait_rst(1'b1);
      `CHK((held >= LH + 3) && (held <= LH + 6), 1'b1)
   endtask : por_long_hold
   // Clock enable low in mid-hold stretches the hold by the frozen cycles
   task automatic freeze_hold();
      @(posedge sys_clk_i);
      req_i.sys_req <= 1'b1;
      @(posedge sys_clk_i);
      req_i.sys_req <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      clk_en <= 1'b0;
      repeat (5) @(posedge sys_clk_i);
      clk_en <= 1'b1;
      #1;
      `CHK({core_rst_n_o, ctrl_rst_o}, 2'h1)
      wait_rst(1'b1);
      `CHK((held >= SH + 5) && (held <= SH + 7), 1'b1)
   endtask : freeze_hold
   // Stop hold ignores a second stop, a system request turns it into a system hold
   task automatic stop_then_sys();
      @(posedge sys_clk_i);
      req_i.stop_req <= 1'b1;
      @(posedge sys_clk_i);
      req_i.stop_req <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      req_i.stop_req <= 1'b1;
      @(posedge sys_clk_i);
      req_i.stop_req <= 1'b0;
      req_i.sys_req <= 1'b1;
      #1;
      `CHK({ctrl_rst_o, core_rst_n_o}, 2'h0)
      @(posedge sys_clk_i);
      req_i.sys_req <= 1'b0;
      #1;
      `CHK(ctrl_rst_o, 1'b1)
      wait_rst(1'b1);
      `CHK((held >= SH + 6) && (held <= SH + 8), 1'b1)
      `CHK({saw_ctrl, saw_wdosc}, 2'h3)
   endtask : stop_then_sys
   initial begin
      repeat (10) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      wait_rst(1'b1);
      run_hold(1'b1, 1'b0, SH);
      run_hold(1'b0, 1'b0, SH);
      run_hold(1'b1, 1'b1, LH);
      run_hold(1'b0, 1'b1, LH);
      por_long_hold();
      pin_extend();
      clock_back_to_prec();
      freeze_hold();
      stop_then_sys();
      close_out();
   end
   // Watchdog on the whole run
   initial begin
      #400000;
      n_mismatch++;
      close_out();
   end
endmodule : rst_seq_tb
